// ### bldc_prot_pwm.sv
// control and protection logic of a three-phase brushless driver
// assumes analog detectors arrive as digital flags from outside the clock domain
module bldc_prot_pwm #(
  parameter int LOCK_PERIODS = bldc_pkg::LOCK_PERIODS
) (
  // clock and power-up reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // rotor position sensors
  input wire logic rotor_pos_u_i,
  input wire logic rotor_pos_v_i,
  input wire logic rotor_pos_w_i,
  // logic control inputs
  input wire logic standby_select_i,
  input wire logic enable_i,
  input wire logic brake_n_i,
  input wire logic dir_i,
  input wire logic pwm_i,
  input wire logic passive_mode_i,
  // analog detectors
  input wire bldc_pkg::bldc_fault_s fault_i,
  input wire bldc_pkg::bldc_cmp_s cmp_i,
  input wire logic [2:0] oc_det_i,
  input wire logic [2:0] neg_det_i,
  // gate drive
  output bldc_pkg::bldc_gate_s gate_o,
  // status
  output logic speed_pulse_out_o,
  output logic lock_o,
  output logic fault_od_o,
  output logic fault_od_oe_o
);

  // synchronised inputs
  logic [bldc_pkg::SYNC_W-1:0] raw;
  logic [bldc_pkg::SYNC_W-1:0] syn;
  logic [2:0] pos;
  logic standby;
  logic disable_req;
  logic brake_n;
  logic dir;
  logic pwm_logic;
  logic passive;
  bldc_pkg::bldc_fault_s flt;
  bldc_pkg::bldc_cmp_s cmp;
  logic [2:0] oc_det;
  logic [2:0] neg_det;

  // state
  logic [bldc_pkg::OSC_W-1:0] osc_r;
  logic [2:0] pos_r;
  logic dir_r;
  logic speed_r;
  logic tsd_r;
  logic lock_r;
  logic [bldc_pkg::LOCK_W-1:0] lock_cnt_r;
  logic [bldc_pkg::OCOFF_W-1:0] ocoff_r;
  logic chop_on_r;
  logic [bldc_pkg::OSC_W-1:0] blank_r;
  logic fault_oe_r;
  logic [1:0] warm_r;

  // combinational terms
  logic warm;
  logic fault_any;
  logic osc_bottom;
  logic osc_falling;
  logic pos_change;
  logic pos_valid;
  logic phase_change;
  logic dir_change;
  logic release_ev;
  logic lock_run;
  logic ocp_hit;
  logic ocp_off;
  logic shutdown;
  logic int_on;
  logic ext_on;
  logic pwm_on;
  logic [2:0] hi_sel;
  logic [2:0] lo_sel;
  bldc_pkg::bldc_sw_e want [3];

  // every pin passes two flops before any logic reads it
  assign raw = {rotor_pos_w_i, rotor_pos_v_i, rotor_pos_u_i,
                standby_select_i, enable_i, brake_n_i, dir_i,
                pwm_i, passive_mode_i, fault_i, cmp_i, oc_det_i, neg_det_i};

  bldc_sync #(
    .W(bldc_pkg::SYNC_W)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .d_i(raw),
    .q_o(syn)
  );

  // unpack the synchronised bank
  assign pos = syn[24:22];
  assign standby = syn[21];
  assign disable_req = syn[20];
  assign brake_n = syn[19];
  assign dir = syn[18];
  assign pwm_logic = syn[17];
  assign passive = syn[16];
  assign flt = syn[15:10];
  assign cmp = syn[9:6];
  assign oc_det = syn[5:3];
  assign neg_det = syn[2:0];

  // pwm oscillator: rising ramp then a short falling part
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      osc_r <= '0;
    end else if (standby) begin
      osc_r <= '0;
    end else if (osc_r == bldc_pkg::OSC_W'(bldc_pkg::OSC_CYC - 1)) begin
      osc_r <= '0;
    end else begin
      osc_r <= osc_r + 1'b1;
    end
  end

  // bottom point is the wrap; falling part is the last 5 percent
  assign osc_bottom = !standby && (osc_r == bldc_pkg::OSC_W'(bldc_pkg::OSC_CYC - 1));
  assign osc_falling = (osc_r >= bldc_pkg::OSC_W'(bldc_pkg::OSC_RISE_CYC));

  // rotor position and direction history
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pos_r <= '0;
      dir_r <= 1'b0;
    end else begin
      pos_r <= pos;
      dir_r <= dir;
    end
  end

  // the sync bank reads zero for two edges after reset while pos_r is
  // already zero; a rotor parked on a valid step would then look like a
  // phase change and toggle the speed pulse right after power-up
  // limitation: a real step in those first edges is missed and never toggles the speed pulse
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      warm_r <= 2'h0;
    end else if (warm_r != 2'h3) begin
      warm_r <= warm_r + 2'h1;
    end
  end

  assign warm = (warm_r == 2'h3);

  assign pos_change = warm && (pos != pos_r);
  assign pos_valid = (pos != 3'b000) && (pos != 3'b111);
  assign phase_change = pos_change && pos_valid;
  assign dir_change = (dir != dir_r);

  // speed pulse toggles on each commutation step
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      speed_r <= 1'b0;
    end else if (standby) begin
      speed_r <= speed_r;
    end else if (phase_change) begin
      speed_r <= !speed_r;
    end
  end

  assign speed_pulse_out_o = speed_r;

  // thermal latch; the cool flag means below trip minus hysteresis
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tsd_r <= 1'b0;
    end else if (flt.tsd_hot) begin
      tsd_r <= 1'b1;
    end else if (flt.tsd_cool) begin
      tsd_r <= 1'b0;
    end
  end

  // any release event clears counter and lock; power-up is the reset
  // the position strobe is any code change, not only the valid steps that clock the speed pulse
  assign release_ev = !brake_n || disable_req || dir_change || pos_change;

  // the counter clears and holds at zero only for regulator undervoltage and standby
  assign lock_run = !flt.reg_uv && !standby;

  // lock counter advances once per oscillator period
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lock_cnt_r <= '0;
      lock_r <= 1'b0;
    end else if (release_ev) begin
      lock_cnt_r <= '0;
      lock_r <= 1'b0;
    end else if (!lock_run) begin
      lock_cnt_r <= '0;
      lock_r <= lock_r;
    end else if (lock_r) begin
      lock_cnt_r <= lock_cnt_r; // latched lock waits for a release event
    end else if (osc_bottom) begin
      if (lock_cnt_r == bldc_pkg::LOCK_W'(LOCK_PERIODS - 1)) begin
        lock_r <= 1'b1;
        lock_cnt_r <= '0;
      end else begin
        lock_cnt_r <= lock_cnt_r + 1'b1;
      end
    end
  end

  assign lock_o = lock_r;

  // output detector flags any phase overcurrent
  assign ocp_hit = |oc_det;

  // overcurrent off timer, counted in oscillator bottoms
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ocoff_r <= '0;
    end else if (standby) begin
      ocoff_r <= '0;
    end else if (ocp_hit) begin
      ocoff_r <= bldc_pkg::OCOFF_W'(bldc_pkg::OCOFF_PERIODS);
    end else if (osc_bottom && (ocoff_r != '0)) begin
      ocoff_r <= ocoff_r - 1'b1;
    end
  end

  assign ocp_off = (ocoff_r != '0);

  // every protection and the lock force all phases to float
  assign shutdown = standby || flt.reg_uv || flt.cp_uv || flt.overvoltage_protect || tsd_r || ocp_off || lock_r;

  // peak current chopper: on at bottom, off at peak after blanking
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      chop_on_r <= 1'b0;
      blank_r <= '0;
    end else if (standby) begin
      chop_on_r <= 1'b0;
      blank_r <= '0;
    end else if (osc_bottom) begin
      chop_on_r <= 1'b1;
      blank_r <= bldc_pkg::OSC_W'(bldc_pkg::BLANK_CYC);
    end else if (blank_r != '0) begin
      blank_r <= blank_r - 1'b1;
    end else if (cmp.cur_peak) begin
      chop_on_r <= 1'b0;
    end
  end

  assign int_on = chop_on_r;

  // duty compare: low disables, full gives 100 percent, else ramp compare
  // the falling part is forced off unless the duty voltage is above full
  assign ext_on = !cmp.duty_low && (cmp.duty_full || (cmp.duty_on && !osc_falling));

  // all three sources must ask for on; any off wins
  assign pwm_on = int_on && ext_on && pwm_logic;

  // commutation table; reverse direction swaps high and low
  always_comb begin
    hi_sel = 3'b000;
    lo_sel = 3'b000;
    case (pos)
      3'b101: begin
        hi_sel = 3'b001;
        lo_sel = 3'b010;
      end
      3'b001: begin
        hi_sel = 3'b001;
        lo_sel = 3'b100;
      end
      3'b011: begin
        hi_sel = 3'b010;
        lo_sel = 3'b100;
      end
      3'b010: begin
        hi_sel = 3'b010;
        lo_sel = 3'b001;
      end
      3'b110: begin
        hi_sel = 3'b100;
        lo_sel = 3'b001;
      end
      3'b100: begin
        hi_sel = 3'b100;
        lo_sel = 3'b010;
      end
      default: begin
        hi_sel = 3'b000;
        lo_sel = 3'b000;
      end
    endcase
    if (!dir) begin
      {hi_sel, lo_sel} = {lo_sel, hi_sel};
    end
  end

  // per-phase request: disable floats, brake shorts low, else commutate
  // pwm off keeps the low switch and releases the high one; in passive
  // mode the high phase's low switch rectifies while recirculation shows
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      want[i] = bldc_pkg::BLDC_SW_OFF;
      if (shutdown || disable_req) begin
        want[i] = bldc_pkg::BLDC_SW_OFF;
      end else if (!brake_n) begin
        want[i] = bldc_pkg::BLDC_SW_LO;
      end else if (lo_sel[i]) begin
        want[i] = bldc_pkg::BLDC_SW_LO;
      end else if (hi_sel[i] && pwm_on) begin
        want[i] = bldc_pkg::BLDC_SW_HI;
      end else if (hi_sel[i] && passive && neg_det[i]) begin
        want[i] = bldc_pkg::BLDC_SW_LO;
      end else begin
        want[i] = bldc_pkg::BLDC_SW_OFF;
      end
    end
  end

  // one dead-time driver per phase
  for (genvar g = 0; g < 3; g++) begin : g_phase
    bldc_phase_gate u_gate (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .want_i(want[g]),
      .hi_o(gate_o.hi[g]),
      .lo_o(gate_o.lo[g])
    );
  end

  // listed faults for the indicator; thermal shutdown itself is not one,
  // the alarm flag trips well before it
  assign fault_any = flt.reg_uv || flt.cp_uv || flt.overvoltage_protect ||
                     flt.therm_alarm || ocp_off || lock_r;

  // open-drain fault indicator pulls low while a listed fault stands
  // standby leaves it floating, the bias being cut
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_oe_r <= 1'b0;
    end else begin
      fault_oe_r <= !standby && fault_any;
    end
  end

  assign fault_od_oe_o = fault_oe_r;
  assign fault_od_o = 1'b0;

endmodule

// ### bldc_pkg.sv
// constants, carriers and timing for the motor protection and pwm logic
// assumes a 20 mhz system clock and comparator flags already digital
package bldc_pkg;

  // clock and oscillator timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int OSC_PERIOD_NS = 40000;
  localparam int OSC_RISE_PCT = 95;
  localparam int OSC_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OSC_RISE_CYC = OSC_CYC * OSC_RISE_PCT / 100;
  localparam int OSC_W = 10;

  // blanking after chop turn-on, a least time so rounded up
  localparam int BLANK_NS = 2000;
  localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // dead time between high and low switch, least time rounded up
  localparam int DEAD_NS = 300;
  localparam int DEAD_CYC = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_W = 4;

  // lock time is 20 ms per nf of timer cap, counted in oscillator periods
  localparam int LOCK_CAP_NF = 100;
  localparam int LOCK_TIME_MS = 20 * LOCK_CAP_NF;
  localparam int LOCK_PERIODS = LOCK_TIME_MS * 1000 / (OSC_PERIOD_NS / 1000);
  localparam int LOCK_W = 17;

  // overcurrent off time as a division of the oscillator
  localparam int OCOFF_PERIODS = 8;
  localparam int OCOFF_W = 4;

  // width of the input synchroniser bank
  localparam int SYNC_W = 25;

  // analog fault detector flags
  typedef struct packed {
    logic reg_uv;
    logic cp_uv;
    logic overvoltage_protect;
    logic tsd_hot;
    logic tsd_cool;
    logic therm_alarm;
  } bldc_fault_s;

  // comparator flags from the chopper and duty compare
  typedef struct packed {
    logic cur_peak;
    logic duty_low;
    logic duty_full;
    logic duty_on;
  } bldc_cmp_s;

  // gate requests for the three phases, index 0 = u
  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } bldc_gate_s;

  // per-phase switch state
  typedef enum logic [1:0] {
    BLDC_SW_OFF = 2'b00,
    BLDC_SW_LO = 2'b01,
    BLDC_SW_HI = 2'b10
  } bldc_sw_e;

endpackage

// ### bldc_sync.sv
// two-flop synchroniser bank for pin inputs
// assumes inputs are asynchronous to sys_clk_i
module bldc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d_i;
      q_r <= meta_r;
    end
  end

  assign q_o = q_r;

endmodule

// ### bldc_phase_gate.sv
// one half-bridge drive with dead time between switch changes
// assumes the request never asks for high and low together
module bldc_phase_gate (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // requested state
  input wire bldc_pkg::bldc_sw_e want_i,
  // gate drive
  output logic hi_o,
  output logic lo_o
);

  bldc_pkg::bldc_sw_e state_r;
  logic [bldc_pkg::DEAD_W-1:0] dead_r;

  // leaving a conducting state always passes through off for the dead time
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= bldc_pkg::BLDC_SW_OFF;
      dead_r <= '0;
    end else if (want_i != state_r) begin
      if (state_r != bldc_pkg::BLDC_SW_OFF) begin
        state_r <= bldc_pkg::BLDC_SW_OFF;
        dead_r <= bldc_pkg::DEAD_W'(bldc_pkg::DEAD_CYC);
      end else if (dead_r != '0) begin
        dead_r <= dead_r - 1'b1;
      end else begin
        state_r <= want_i;
      end
    end else if (dead_r != '0) begin
      dead_r <= dead_r - 1'b1;
    end
  end

  assign hi_o = (state_r == bldc_pkg::BLDC_SW_HI);
  assign lo_o = (state_r == bldc_pkg::BLDC_SW_LO);

endmodule

// ### bldc_rotor_model.sv
// rotor position sensor model: six valid steps and two error codes
// assumes the bench changes the step index off the sampling edge
module bldc_rotor_model (
  // step select, 0..5 valid, 6 all low, 7 all high
  input wire logic [2:0] step_i,
  // sensor lines
  output logic u_o,
  output logic v_o,
  output logic w_o
);
  // sensor code per step, u in the top bit
  localparam logic [2:0] CODE [8] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h0, 3'h7};

  // a real sensor never glitches between steps, so a plain lookup will do
  assign {u_o, v_o, w_o} = CODE[step_i];
endmodule

// ### bldc_prot_pwm_sva.sv
// assertions on the pins of the motor protection and pwm logic
// assumes it is bound to the top module and sees only its ports
module bldc_prot_pwm_sva (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // inputs
  input wire logic rotor_pos_u_i,
  input wire logic rotor_pos_v_i,
  input wire logic rotor_pos_w_i,
  input wire logic standby_select_i,
  input wire logic pwm_i,
  input wire bldc_pkg::bldc_fault_s fault_i,
  input wire bldc_pkg::bldc_cmp_s cmp_i,
  input wire logic [2:0] oc_det_i,
  // outputs
  input wire bldc_pkg::bldc_gate_s gate_o,
  input wire logic speed_pulse_out_o,
  input wire logic lock_o,
  input wire logic fault_od_o,
  input wire logic fault_od_oe_o
);
  // one domain; inputs pass two sync flops, so four cycles is a safe lead
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_standby_off: assert property (standby_select_i[*4] |=> gate_o == '0)
    else $error("gates on in standby");
  a_supply_off: assert property (
    (fault_i.reg_uv || fault_i.cp_uv || fault_i.overvoltage_protect)[*4] |=> gate_o == '0)
    else $error("gates on with a supply fault");
  a_thermal_hold: assert property (
    fault_i.tsd_hot[*3] ##1 (!fault_i.tsd_cool)[*5] |-> gate_o == '0)
    else $error("thermal latch let go early");
  a_lock_off: assert property (lock_o[*2] |-> gate_o == '0)
    else $error("gates on while locked");
  a_od_data_low: assert property (fault_od_o == 1'b0)
    else $error("fault pin data not low");
  a_ovp_flag: assert property (
    (fault_i.overvoltage_protect && !standby_select_i)[*4] |-> fault_od_oe_o)
    else $error("fault pin not pulled on overvoltage");
  a_no_overlap: assert property ((gate_o.hi & gate_o.lo) == 3'h0)
    else $error("high and low switch on together");
  a_dead_gap: assert property ($fell(gate_o.hi[0]) |-> (!gate_o.lo[0])[*6])
    else $error("dead time too short");
  a_pwm_off: assert property ((!pwm_i)[*4] |=> gate_o.hi == 3'h0)
    else $error("high switch on without pwm request");
  a_duty_low: assert property (cmp_i.duty_low[*4] |=> gate_o.hi == 3'h0)
    else $error("high switch on below duty floor");
  a_ocp_off: assert property ((|oc_det_i)[*4] |=> gate_o == '0)
    else $error("gates on during overcurrent");
  a_speed_still: assert property (
    $stable({rotor_pos_u_i, rotor_pos_v_i, rotor_pos_w_i})[*6] |=> $stable(speed_pulse_out_o))
    else $error("speed pulse moved without rotor change");
endmodule

bind bldc_prot_pwm bldc_prot_pwm_sva chk_u (
  .sys_clk_i, .resetn_i, .rotor_pos_u_i, .rotor_pos_v_i, .rotor_pos_w_i,
  .standby_select_i, .pwm_i, .fault_i, .cmp_i, .oc_det_i, .gate_o,
  .speed_pulse_out_o, .lock_o, .fault_od_o, .fault_od_oe_o
);

// ### bldc_prot_pwm_bench.sv
// self-checking bench for the motor protection and pwm logic
// assumes the lock time is cut to three oscillator periods
module bldc_prot_pwm_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LP = 3;
  localparam int PER = bldc_pkg::OSC_CYC;
  // step, high switches, low switches per row
  localparam logic [8:0] ROWS [8] = '{9'h00a, 9'h04c, 9'h094, 9'h0d1, 9'h121, 9'h162, 9'h180, 9'h1c0};
  // fault pin expected per protection case
  localparam logic [7:0] PROT_OE = 8'hce;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [2:0] step = 3'h6;
  logic standby = 1'b0;
  logic en = 1'b0;
  logic brk_n = 1'b1;
  logic dir = 1'b1;
  logic pwm = 1'b1;
  logic exp_spd = 1'b0;
  logic [2:0] oc = 3'h0;
  logic pas = 1'b0;
  logic [2:0] neg = 3'h0;
  bldc_pkg::bldc_fault_s flt = '0;
  bldc_pkg::bldc_cmp_s cmp = 4'h3;
  bldc_pkg::bldc_gate_s gate;
  logic u, v, w, spd, lock, od, od_oe;
  int failures = 0;
  int checks_done = 0;

  // 20 mhz clock
  always #25 sys_clk_i = ~sys_clk_i;

  bldc_rotor_model rotor_u (.step_i(step), .u_o(u), .v_o(v), .w_o(w));
  bldc_prot_pwm #(.LOCK_PERIODS(LP)) dut_u (
    .sys_clk_i, .resetn_i, .rotor_pos_u_i(u), .rotor_pos_v_i(v), .rotor_pos_w_i(w),
    .standby_select_i(standby), .enable_i(en), .brake_n_i(brk_n), .dir_i(dir), .pwm_i(pwm),
    .passive_mode_i(pas), .fault_i(flt), .cmp_i(cmp), .oc_det_i(oc), .neg_det_i(neg),
    .gate_o(gate), .speed_pulse_out_o(spd), .lock_o(lock), .fault_od_o(od), .fault_od_oe_o(od_oe));

  // stimulus moves on the falling edge only
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask

  task automatic check(input string name, input logic [5:0] seen, input logic [5:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stop_test;
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // next valid step; any rotor change also clears the lock count
  task automatic adv;
    step = (step >= 3'h5) ? 3'h0 : step + 3'h1;
  endtask

  // hold the rotor still past the lock time
  task automatic relock;
    cyc(LP * PER + 100);
    check("lock", lock, 1'b1);
  endtask

  task automatic prot(input int k, input logic val);
    case (k)
      0: standby = val;
      1: flt.reg_uv = val;
      2: flt.cp_uv = val;
      3: flt.overvoltage_protect = val;
      4: flt.tsd_hot = val;
      5: en = val;
      default: flt.therm_alarm = val;
    endcase
  endtask

  // main sequence: table first, then the awkward cases
  initial begin
    cyc(3);
    check("gate_rst", gate, 6'h00);
    resetn_i = 1'b1;
    cyc(PER + 20);
    for (int d = 1; d >= 0; d--) begin
      dir = d[0];
      for (int i = 0; i < 8; i++) begin
        step = ROWS[i][8:6];
        if (i < 6) exp_spd = ~exp_spd;
        cyc(20);
        check("gate", gate, d[0] ? ROWS[i][5:0] : {ROWS[i][2:0], ROWS[i][5:3]});
        check("speed", spd, exp_spd);
      end
    end
    dir = 1'b1;
    step = 3'h0;
    for (int k = 0; k < 5; k++) begin
      relock();
      check("gate_lock", gate, 6'h00);
      check("fault_lock", od_oe, 1'b1);
      if (k == 0) brk_n = 1'b0;
      if (k == 1) en = 1'b1;
      if (k == 2) dir = ~dir;
      if (k == 3) step = 3'h1;
      if (k == 4) resetn_i = 1'b0;
      cyc(3);
      brk_n = 1'b1;
      en = 1'b0;
      resetn_i = 1'b1;
      cyc(10);
      check("lock_rel", lock, 1'b0);
      if (k == 4) check("speed_rst", spd, 1'b0);
      if (k == 3) check("resume", gate.lo, 3'h1);
    end
    flt.cp_uv = 1'b1;
    relock();
    flt.cp_uv = 1'b0;
    cyc(20);
    check("lock_kept", lock, 1'b1);
    adv();
    flt.reg_uv = 1'b1;
    cyc(LP * PER + 100);
    check("lock_reg_uv", lock, 1'b0);
    flt.reg_uv = 1'b0;
    for (int k = 0; k < 7; k++) begin
      prot(k, 1'b1);
      cyc(10);
      check("fault_pin", od_oe, PROT_OE[k]);
      if (k != 6) check("gate_prot", gate, 6'h00);
      prot(k, 1'b0);
      adv();
      cyc(20);
      if (k == 4) begin
        check("tsd_held", gate, 6'h00);
        flt.tsd_cool = 1'b1;
        cyc(20);
        flt.tsd_cool = 1'b0;
      end
      check("gate_back", |gate.lo, 1'b1);
    end
    adv();
    cyc(PER);
    check("hi_on", |gate.hi, 1'b1);
    pwm = 1'b0;
    cyc(10);
    check("hi_pwm", gate.hi, 3'h0);
    // passive mode: recirculating high phase gets its low switch
    pas = 1'b1;
    neg = 3'h7;
    cyc(20);
    check("sync_rect", 6'($countones(gate.lo)), 6'h2);
    pas = 1'b0;
    neg = 3'h0;
    cyc(20);
    check("rect_off", 6'($countones(gate.lo)), 6'h1);
    pwm = 1'b1;
    cmp = 4'h7;
    cyc(10);
    check("hi_duty", gate.hi, 3'h0);
    // peak held high: only the blanking window lets the switch on
    cmp = 4'hb;
    adv();
    cyc(50);
    // start from a fresh bottom so the blanking window is seen whole
    for (int i = 0; i < PER && gate.hi !== 3'h0; i++) cyc(1);
    for (int i = 0; i < PER && gate.hi === 3'h0; i++) cyc(1);
    cyc(20);
    check("hi_blank", |gate.hi, 1'b1);
    cyc(40);
    check("hi_peak", gate.hi, 3'h0);
    cmp = 4'h3;
    oc = 3'h2;
    cyc(10);
    check("gate_ocp", gate, 6'h00);
    oc = 3'h0;
    for (int i = 0; i < 20; i++) begin
      adv();
      cyc(PER / 2);
      if (i == 8) check("ocp_held", od_oe, 1'b1);
    end
    check("ocp_over", od_oe, 1'b0);
    stop_test();
  end

  // watchdog, about twice the expected run
  initial begin
    cyc(60000);
    failures++;
    stop_test();
  end
endmodule
